// ==== common/dram_mode_pkg.sv ====
// constants for the mode register six and parity/crc status block
// assumes one command clock; command pins already sampled on it
// Function
// R01: a detected write crc error sets the crc error flag to 1
// R02: crc error flag holds until cleared by a mode register set
// R03: parity checking is off by default; nonzero latency turns it on
// R04: with parity on, a command runs only after its parity is found good
// R05: even parity covers act, ras, cas, we, address, bank and bank group
// R06: clock enable, termination control and chip select are left out of parity
// R07: mode register set loads register six from bank group, bank and address pins
// R08: controller holds ras, cas and we low for a mode register set
// R09: controller writes zero to bits 21 and 17
// R10: bits 12:10 give column delay 4 to 8 clocks; codes above 4 reserved
// R11: controller programs column delay to suit the operating frequency
// R12: same group column commands accepted at max of 4 clocks or programmed delay; code checks only against the last accepted column command
// R13: controller keeps receive equalization bits 13, 9, 8 at 000
// R14: controller sets calibration enable bit 7 when writing bits 6:0
// R15: bit 6 picks reference range one or two
// R16: bits 5:0 pick one of fifty reference steps
// R17: reference may be shown on a low data line for evaluation
// R18: controller owns reference calibration through writes and reads
// R19: latency codes 1 to 3 give 4 to 6 clocks; 0 off; others reserved
// R20: non-persistent mode stops checking while parity flag set
// R21: parity error sets flag; it holds until a mode register set clears it
// R22: select code 110 on bits 20:18 addresses register six; 111 unused
package dram_mode_pkg;
    // command word layout
    localparam int CMD_W      = 23;
    localparam int CMD_ACT    = 22;
    localparam int CMD_RAS    = 21;
    localparam int CMD_CAS    = 20;
    localparam int CMD_WE     = 19;
    localparam int CMD_BG_HI  = 18;
    localparam int CMD_BG_LO  = 17;
    localparam int CMD_SEL_LO = 15;
    localparam int CMD_A17    = 14;
    localparam int CMD_A_HI   = 13;
    // mode register layout
    localparam int MR_W       = 22;
    localparam logic [21:0] REG_SIX_RESET = 22'h000000;
    localparam logic [2:0]  SEL_FIFTH     = 3'h5;
    localparam logic [2:0]  SEL_SIX       = 3'h6;
    localparam int CCD_HI     = 12;
    localparam int CCD_LO     = 10;
    localparam int EQ_TOP     = 13;
    localparam int EQ_MID     = 9;
    localparam int EQ_LOW     = 8;
    localparam int CAL_EN     = 7;
    localparam int CAL_RANGE  = 6;
    localparam int VAL_HI     = 5;
    localparam logic [5:0] VREF_STEPS = 6'h32;
    localparam logic [3:0] CCD_BASE   = 4'h4;
    localparam logic [2:0] CCD_TOP    = 3'h4;
    localparam logic [3:0] CCD_RESVD  = 4'h8;
    // fifth register fields
    localparam int PL_HI      = 2;
    localparam int CRC_STAT   = 3;
    localparam int PAR_STAT   = 4;
    localparam int PERSIST    = 9;
    localparam logic [2:0] PL_TOP  = 3'h3;
    localparam logic [2:0] PL_BASE = 3'h3;
    localparam int LAT_W      = 3;
    localparam int LAT_MAX    = 6;
endpackage : dram_mode_pkg

// ==== common/cmd_pipe_if.sv ====
// carrier between the status block and its parity delay line
// assumes both ends run on the command clock
`timescale 1ns/1ps
`default_nettype none
interface cmd_pipe_if;
    logic                             inValid;
    logic [dram_mode_pkg::CMD_W-1:0] inCmd;
    logic                             inParity;
    logic [dram_mode_pkg::LAT_W-1:0] latency;
    logic                             outValid;
    logic [dram_mode_pkg::CMD_W-1:0] outCmd;
    logic                             outParityErr;
    modport src  (output inValid, inCmd, inParity, latency,
                  input outValid, outCmd, outParityErr);
    modport sink (input inValid, inCmd, inParity, latency,
                  output outValid, outCmd, outParityErr);
endinterface : cmd_pipe_if
`default_nettype wire

// ==== hdl/cmd_parity_pipe.sv ====
// parity computation and latency delay line for received commands
// assumes latency is 0 or between 4 and DEPTH while commands flow
`timescale 1ns/1ps
`default_nettype none
module cmd_parity_pipe #(
    parameter int DEPTH = dram_mode_pkg::LAT_MAX
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // command stream
    cmd_pipe_if.sink pipe
);
    if (DEPTH < dram_mode_pkg::LAT_MAX) begin : g_depth_check
        $error("delay line shorter than largest parity latency");
    end

    logic [DEPTH:1]                  valQ;
    logic [DEPTH:1]                  valD;
    logic [DEPTH:1]                  errQ;
    logic [DEPTH:1]                  errD;
    logic [dram_mode_pkg::CMD_W-1:0] cmdQ [1:DEPTH];
    logic [dram_mode_pkg::CMD_W-1:0] cmdD [1:DEPTH];
    logic                            inErr;
    int                              tap;

    // even parity over the command word only; no chip select in it
    assign inErr = ^{pipe.inCmd, pipe.inParity}; // R05 R06

    // shift one stage per clock; a stage empties once delivered so no command runs twice
    always_comb begin
        valD[1] = pipe.inValid && tap != 0;
        errD[1] = inErr;
        cmdD[1] = pipe.inCmd;
        for (int i = 2; i <= DEPTH; i++) begin
            valD[i] = valQ[i-1] && (i - 1 != tap);
            errD[i] = errQ[i-1];
            cmdD[i] = cmdQ[i-1];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            valQ <= '0;
            errQ <= '0;
            for (int i = 1; i <= DEPTH; i++) begin
                cmdQ[i] <= '0;
            end
        end else begin
            valQ <= valD;
            errQ <= errD;
            cmdQ <= cmdD;
        end
    end

    // tap select; zero latency passes straight through
    always_comb begin
        tap = (int'(pipe.latency) > DEPTH) ? DEPTH : int'(pipe.latency);
        if (tap == 0) begin
            pipe.outValid     = pipe.inValid;
            pipe.outParityErr = inErr;
            pipe.outCmd       = pipe.inCmd;
        end else begin
            pipe.outValid     = valQ[tap];
            pipe.outParityErr = errQ[tap];
            pipe.outCmd       = cmdQ[tap];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_parity_calc;
        pipe.inValid && pipe.latency == 3'h0 |-> pipe.outParityErr == inErr;
    endproperty
    a_parity_calc: assert property (p_parity_calc) // R05
        else $error("parity error flag not the xor of the word");

    property p_delay_five;
        pipe.inValid && pipe.latency == 3'h5
            |-> ##5 (pipe.outValid || pipe.latency != 3'h5);
    endproperty
    a_delay_five: assert property (p_delay_five) // R19
        else $error("command not delivered five clocks later");
endmodule : cmd_parity_pipe
`default_nettype wire

// ==== hdl/dram_mode_six_and_parity_status.sv ====
// mode register six decode, parity check gate and error status flags
// assumes command pins sampled on clock; one command per clock at most
`timescale 1ns/1ps
`default_nettype none
module dram_mode_six_and_parity_status (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // command and address pins
    input  wire logic        csB,
    input  wire logic        actB,
    input  wire logic        rasB,
    input  wire logic        casB,
    input  wire logic        weB,
    input  wire logic [1:0]  bankGroup,
    input  wire logic [1:0]  bankAddr,
    input  wire logic        addr17,
    input  wire logic [13:0] addr,
    input  wire logic        cmdAddrParityInput,
    // write crc checker event
    input  wire logic        writeCrcError,
    // command execution
    output logic             cmdExecute,
    output logic             parityErrorPulse,
    output logic             columnCmdAccept,
    output logic             columnCmdTooEarly,
    // status
    output logic             crcErrorStatus,
    output logic             parityErrorStatus,
    output logic             parityEnabled,
    output logic             parityPersistent,
    output logic [2:0]       parityLatency,
    // register six fields
    output logic [21:0]      columnDelayAndReferenceCal_q,
    output logic [3:0]       sameGroupColumnDelay,
    output logic [2:0]       receiveEqualizationField,
    output logic             vrefCalEnable,
    output logic             vrefRange,
    output logic [5:0]       vrefValue,
    output logic             vrefValueLegal,
    output logic             vrefMonitorEnable
);
    cmd_pipe_if pipe ();

    logic [21:0] regSixD;
    logic [2:0]  plCode_q;
    logic [2:0]  plCode_d;
    logic        persist_q;
    logic        persist_d;
    logic        crc_q;
    logic        crc_d;
    logic        par_q;
    logic        par_d;
    logic [3:0]  gap_q;
    logic [3:0]  gap_d;
    logic        haveCol_q;
    logic        haveCol_d;
    logic [1:0]  lastBg_q;
    logic [1:0]  lastBg_d;
    logic [22:0] oc;
    logic [21:0] loadVal;
    logic [2:0]  mrSel;
    logic        isMrs;
    logic        isCol;
    logic        checkActive;
    logic        mrs5;
    logic        mrs6;
    logic        colCand;
    logic [2:0]  ccdCode;

    // commands enter the delay line whenever chip select is low and parity latency is nonzero
    assign pipe.inValid  = !csB; // R06
    assign pipe.inCmd    = {actB, rasB, casB, weB, bankGroup, bankAddr, addr17, addr}; // R05
    assign pipe.inParity = cmdAddrParityInput;
    assign pipe.latency  = parityEnabled ? 3'(plCode_q + dram_mode_pkg::PL_BASE) : 3'h0; // R19

    cmd_parity_pipe #(
        .DEPTH (dram_mode_pkg::LAT_MAX)
    ) u_pipe (
        .clock (clock),
        .rst_b (rst_b),
        .pipe  (pipe)
    );

    // decode of the command leaving the delay line
    assign oc      = pipe.outCmd;
    assign isMrs   = oc[dram_mode_pkg::CMD_ACT] && !oc[dram_mode_pkg::CMD_RAS]
                     && !oc[dram_mode_pkg::CMD_CAS] && !oc[dram_mode_pkg::CMD_WE]; // R08
    assign isCol   = oc[dram_mode_pkg::CMD_ACT] && oc[dram_mode_pkg::CMD_RAS]
                     && !oc[dram_mode_pkg::CMD_CAS];
    assign mrSel   = oc[dram_mode_pkg::CMD_BG_LO:dram_mode_pkg::CMD_SEL_LO]; // R22
    assign loadVal = {oc[dram_mode_pkg::CMD_BG_HI:dram_mode_pkg::CMD_A17], 3'h0,
                      oc[dram_mode_pkg::CMD_A_HI:0]}; // R07 R09

    // parity gate: off, persistent, or paused by a set flag
    assign parityEnabled    = plCode_q != 3'h0 && plCode_q <= dram_mode_pkg::PL_TOP; // R03 R19
    assign parityPersistent = persist_q;
    assign parityLatency    = pipe.latency;
    assign checkActive      = parityEnabled && (persist_q || !par_q); // R20
    assign parityErrorPulse = pipe.outValid && pipe.outParityErr && checkActive; // R04
    assign cmdExecute       = pipe.outValid && !parityErrorPulse; // R04
    assign mrs5 = cmdExecute && isMrs && mrSel == dram_mode_pkg::SEL_FIFTH;
    assign mrs6 = cmdExecute && isMrs && mrSel == dram_mode_pkg::SEL_SIX; // R22

    // same group column spacing check
    assign ccdCode = columnDelayAndReferenceCal_q[dram_mode_pkg::CCD_HI:dram_mode_pkg::CCD_LO];
    assign sameGroupColumnDelay = (ccdCode > dram_mode_pkg::CCD_TOP) ? dram_mode_pkg::CCD_RESVD
                                  : dram_mode_pkg::CCD_BASE + {1'b0, ccdCode}; // R10
    assign colCand = cmdExecute && isCol;
    assign columnCmdTooEarly = colCand && haveCol_q && gap_q < sameGroupColumnDelay
                               && oc[dram_mode_pkg::CMD_BG_HI:dram_mode_pkg::CMD_BG_LO]
                                  == lastBg_q; // R12
    assign columnCmdAccept = colCand && !columnCmdTooEarly; // R12

    // next state of registers, flags and spacing tracker
    always_comb begin
        regSixD   = columnDelayAndReferenceCal_q;
        plCode_d  = plCode_q;
        persist_d = persist_q;
        crc_d     = crc_q;
        par_d     = par_q;
        gap_d     = (gap_q == 4'hf) ? gap_q : gap_q + 4'h1;
        haveCol_d = haveCol_q;
        lastBg_d  = lastBg_q;
        if (mrs6) begin
            regSixD = loadVal; // R07
        end
        if (mrs5) begin
            plCode_d  = loadVal[dram_mode_pkg::PL_HI:0]; // R03
            persist_d = loadVal[dram_mode_pkg::PERSIST];
            if (!loadVal[dram_mode_pkg::CRC_STAT]) begin
                crc_d = 1'b0; // R02
            end
            if (!loadVal[dram_mode_pkg::PAR_STAT]) begin
                par_d = 1'b0; // R21
            end
        end
        if (writeCrcError) begin
            crc_d = 1'b1; // R01
        end
        if (parityErrorPulse) begin
            par_d = 1'b1; // R21
        end
        if (columnCmdAccept) begin
            gap_d     = 4'h1;
            haveCol_d = 1'b1;
            lastBg_d  = oc[dram_mode_pkg::CMD_BG_HI:dram_mode_pkg::CMD_BG_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            columnDelayAndReferenceCal_q <= dram_mode_pkg::REG_SIX_RESET;
            plCode_q  <= 3'h0; // R03
            persist_q <= 1'b0;
            crc_q     <= 1'b0;
            par_q     <= 1'b0;
            gap_q     <= 4'hf;
            haveCol_q <= 1'b0;
            lastBg_q  <= 2'h0;
        end else begin
            columnDelayAndReferenceCal_q <= regSixD;
            plCode_q  <= plCode_d;
            persist_q <= persist_d;
            crc_q     <= crc_d;
            par_q     <= par_d;
            gap_q     <= gap_d;
            haveCol_q <= haveCol_d;
            lastBg_q  <= lastBg_d;
        end
    end

    // status flag and register six field outputs
    assign crcErrorStatus    = crc_q;
    assign parityErrorStatus = par_q;
    assign receiveEqualizationField = {columnDelayAndReferenceCal_q[dram_mode_pkg::EQ_TOP],
                                       columnDelayAndReferenceCal_q[dram_mode_pkg::EQ_MID],
                                       columnDelayAndReferenceCal_q[dram_mode_pkg::EQ_LOW]};
    assign vrefCalEnable     = columnDelayAndReferenceCal_q[dram_mode_pkg::CAL_EN];
    assign vrefRange         = columnDelayAndReferenceCal_q[dram_mode_pkg::CAL_RANGE]; // R15
    assign vrefValue         = columnDelayAndReferenceCal_q[dram_mode_pkg::VAL_HI:0]; // R16
    assign vrefValueLegal    = vrefValue < dram_mode_pkg::VREF_STEPS; // R16
    assign vrefMonitorEnable = vrefCalEnable; // R17

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_crc_set;
        writeCrcError |=> crcErrorStatus;
    endproperty
    a_crc_set: assert property (p_crc_set) // R01
        else $error("crc flag not set after crc error");

    property p_crc_hold;
        crcErrorStatus && !mrs5 |=> crcErrorStatus;
    endproperty
    a_crc_hold: assert property (p_crc_hold) // R02
        else $error("crc flag dropped without a register write");

    property p_par_off;
        !parityEnabled |-> !parityErrorPulse && parityLatency == 3'h0;
    endproperty
    a_par_off: assert property (p_par_off) // R03
        else $error("parity active while disabled");

    property p_no_exec;
        parityErrorPulse |-> !cmdExecute
            ##1 (columnDelayAndReferenceCal_q == $past(columnDelayAndReferenceCal_q));
    endproperty
    a_no_exec: assert property (p_no_exec) // R04
        else $error("command executed despite parity error");

    property p_load;
        mrs6 |=> columnDelayAndReferenceCal_q == $past(loadVal);
    endproperty
    a_load: assert property (p_load) // R07
        else $error("register six not loaded from pins");

    property p_ccd;
        ccdCode <= 3'h4 |-> sameGroupColumnDelay == 4'h4 + {1'b0, ccdCode};
    endproperty
    a_ccd: assert property (p_ccd) // R10
        else $error("column delay decode wrong");

    property p_ccd_floor;
        columnCmdAccept ##1 colCand [*1] ##0
            oc[18:17] == $past(oc[18:17]) |-> columnCmdTooEarly;
    endproperty
    a_ccd_floor: assert property (p_ccd_floor) // R12
        else $error("back to back same group column commands accepted");

    property p_vref;
        vrefValueLegal == (vrefValue <= 6'h31);
    endproperty
    a_vref: assert property (p_vref) // R16
        else $error("reference step legality wrong");

    property p_lat;
        parityEnabled |-> parityLatency inside {3'h4, 3'h5, 3'h6};
    endproperty
    a_lat: assert property (p_lat) // R19
        else $error("parity latency out of range");

    property p_nonpersist;
        parityErrorStatus && !parityPersistent |-> !parityErrorPulse;
    endproperty
    a_nonpersist: assert property (p_nonpersist) // R20
        else $error("parity checked while flag set in normal mode");

    property p_par_set;
        parityErrorPulse |=> parityErrorStatus;
    endproperty
    a_par_set: assert property (p_par_set) // R21
        else $error("parity flag not set after parity error");

    c_mrs6: cover property (mrs6);
    c_par_err: cover property (parityErrorPulse);
    c_too_early: cover property (columnCmdTooEarly);
    c_crc_clear: cover property (crcErrorStatus ##1 !crcErrorStatus);
endmodule : dram_mode_six_and_parity_status
`default_nettype wire

// ==== bench/ddr_ctrl_model.sv ====
// memory controller model driving the command and address pins
// assumes one caller process; every pin change lands just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
    // clock
    input  wire logic        clock,
    // command and address pins
    output logic             csB,
    output logic             actB,
    output logic             rasB,
    output logic             casB,
    output logic             weB,
    output logic [1:0]       bankGroup,
    output logic [1:0]       bankAddr,
    output logic             addr17,
    output logic [13:0]      addr,
    output logic             cmdAddrParityInput
);
    // deselected at time zero
    initial begin
        {csB, actB, rasB, casB, weB} = 5'h1f;
        {bankGroup, bankAddr, addr17, addr, cmdAddrParityInput} = 20'h00000;
    end

    // one command cycle; bad flips the parity pin on purpose
    task automatic drive(input logic [3:0] cmd, input logic [1:0] bg, input logic [1:0] ba,
                         input logic a17, input logic [13:0] a, input logic bad);
        @(posedge clock);
        csB <= 1'b0;
        {actB, rasB, casB, weB} <= cmd;
        {bankGroup, bankAddr, addr17, addr} <= {bg, ba, a17, a};
        // even parity; chip select, clock enable, termination left out
        cmdAddrParityInput <= ^{cmd, bg, ba, a17, a} ^ bad;
    endtask : drive

    // mode register set; reserved bits zero; for register six also eq field zero, cal enable set
    task automatic mrs(input logic [2:0] sel, input logic [13:0] a, input logic bad);
        logic [13:0] op;
        op = a;
        if (sel == dram_mode_pkg::SEL_SIX) begin
            op = (a & 14'h1cff) | 14'h0080;
        end
        drive(4'h8, {1'b0, sel[2]}, sel[1:0], 1'b0, op, bad);
    endtask : mrs

    // read command to a bank group
    task automatic col(input logic [1:0] bg);
        drive(4'hd, bg, 2'h0, 1'b0, 14'h0000, 1'b0);
    endtask : col

    // deselect; released pins show the inverse of their last value
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            csB <= 1'b1;
            {actB, rasB, casB, weB} <= ~{actB, rasB, casB, weB};
            {bankGroup, bankAddr, addr17, addr} <= ~{bankGroup, bankAddr, addr17, addr};
            cmdAddrParityInput <= ~cmdAddrParityInput;
        end
    endtask : idle
endmodule : ddr_ctrl_model
`default_nettype wire

// ==== bench/dram_mode_six_and_parity_status_tb_top.sv ====
// self-checking bench for the mode register six and status block
// assumes the controller model drives all command pins
`timescale 1ns/1ps
`default_nettype none
module dram_mode_six_and_parity_status_tb_top;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        writeCrcError = 1'b0;
    logic        csB, actB, rasB, casB, weB, addr17, cmdAddrParityInput;
    logic [1:0]  bankGroup, bankAddr;
    logic [13:0] addr;
    logic        cmdExecute, parityErrorPulse, columnCmdAccept, columnCmdTooEarly;
    logic        crcErrorStatus, parityErrorStatus, parityEnabled, parityPersistent;
    logic [2:0]  parityLatency, receiveEqualizationField;
    logic [21:0] columnDelayAndReferenceCal_q;
    logic [3:0]  sameGroupColumnDelay;
    logic        vrefCalEnable, vrefRange, vrefValueLegal, vrefMonitorEnable;
    logic [5:0]  vrefValue;
    int          n_fail = 0;
    int          n_checks = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    dram_mode_six_and_parity_status dram_mode_six_and_parity_status_i (
        .clock(clock), .rst_b(rst_b), .csB(csB), .actB(actB), .rasB(rasB), .casB(casB),
        .weB(weB), .bankGroup(bankGroup), .bankAddr(bankAddr), .addr17(addr17),
        .addr(addr), .cmdAddrParityInput(cmdAddrParityInput),
        .writeCrcError(writeCrcError), .cmdExecute(cmdExecute),
        .parityErrorPulse(parityErrorPulse), .columnCmdAccept(columnCmdAccept),
        .columnCmdTooEarly(columnCmdTooEarly), .crcErrorStatus(crcErrorStatus),
        .parityErrorStatus(parityErrorStatus), .parityEnabled(parityEnabled),
        .parityPersistent(parityPersistent), .parityLatency(parityLatency),
        .columnDelayAndReferenceCal_q(columnDelayAndReferenceCal_q),
        .sameGroupColumnDelay(sameGroupColumnDelay),
        .receiveEqualizationField(receiveEqualizationField), .vrefCalEnable(vrefCalEnable),
        .vrefRange(vrefRange), .vrefValue(vrefValue), .vrefValueLegal(vrefValueLegal),
        .vrefMonitorEnable(vrefMonitorEnable));

    ddr_ctrl_model ctrl_i (
        .clock(clock), .csB(csB), .actB(actB), .rasB(rasB), .casB(casB), .weB(weB),
        .bankGroup(bankGroup), .bankAddr(bankAddr), .addr17(addr17), .addr(addr),
        .cmdAddrParityInput(cmdAddrParityInput));

    // verdict and end of run
    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for the command outcome, counting cycles of delay
    task automatic waitPulse(input int lat, input logic err);
        int i;
        for (i = 0; i <= 10; i++) begin
            @(negedge clock);
            if (cmdExecute === 1'b1 || parityErrorPulse === 1'b1) break;
            ctrl_i.idle(1);
        end
        if (i > 10) begin
            n_fail++;
            end_sim();
        end
        check(i, lat);
        check({cmdExecute, parityErrorPulse}, {!err, err});
    endtask : waitPulse

    // let the update edge pass
    task automatic settle();
        ctrl_i.idle(1);
        @(negedge clock);
    endtask : settle

    // reset values
    task automatic t_reset();
        check(columnDelayAndReferenceCal_q, dram_mode_pkg::REG_SIX_RESET);
        check({parityEnabled, parityLatency}, 4'h0);
        check({crcErrorStatus, parityErrorStatus, parityPersistent}, 3'h0);
    endtask : t_reset

    // register six load and field decode, every delay code
    task automatic t_mr6();
        logic [13:0] a;
        for (int c = 0; c < 8; c++) begin
            a = {1'b0, c[2:0], 2'b00, 1'b1, c[0], 6'(45 + c)};
            ctrl_i.mrs(3'h6, a, 1'b0);
            waitPulse(0, 1'b0);
            settle();
            check(columnDelayAndReferenceCal_q, 22'h180000 | a);
            check(sameGroupColumnDelay, (c <= 4) ? 4 + c : 8);
            check(vrefRange, c[0]);
            check(vrefValue, 45 + c);
            check(vrefValueLegal, (45 + c) < 50);
            check(receiveEqualizationField, 3'h0);
            check({vrefCalEnable, vrefMonitorEnable}, 2'h3);
        end
        ctrl_i.mrs(3'h4, 14'h1234, 1'b0);
        waitPulse(0, 1'b0);
        settle();
        check(columnDelayAndReferenceCal_q, 22'h180000 | a);
    endtask : t_mr6

    // crc flag set, held, cleared only by a write with bit 3 low
    task automatic t_crc();
        @(posedge clock);
        writeCrcError <= 1'b1;
        @(posedge clock);
        writeCrcError <= 1'b0;
        @(negedge clock);
        check(crcErrorStatus, 1'b1);
        ctrl_i.drive(4'hf, 2'h0, 2'h0, 1'b0, 14'h0000, 1'b0);
        waitPulse(0, 1'b0);
        ctrl_i.mrs(3'h5, 14'h0008, 1'b0);
        waitPulse(0, 1'b0);
        settle();
        check(crcErrorStatus, 1'b1);
        ctrl_i.mrs(3'h5, 14'h0000, 1'b0);
        waitPulse(0, 1'b0);
        settle();
        check(crcErrorStatus, 1'b0);
    endtask : t_crc

    // every latency code, each write timed at the old latency
    task automatic t_latency();
        int prev;
        int lat;
        prev = 0;
        for (int c = 0; c < 8; c++) begin
            lat = (c >= 1 && c <= 3) ? c + 3 : 0;
            ctrl_i.mrs(3'h5, 14'(c), 1'b0);
            waitPulse(prev, 1'b0);
            settle();
            check({parityEnabled, parityLatency}, {lat != 0, 3'(lat)});
            prev = lat;
        end
    endtask : t_latency

    // parity errors in normal and persistent mode at latency 4
    task automatic t_parity();
        ctrl_i.mrs(3'h5, 14'h0001, 1'b0);
        waitPulse(0, 1'b0);
        ctrl_i.mrs(3'h6, 14'h0111, 1'b1);
        waitPulse(4, 1'b1);
        settle();
        check(parityErrorStatus, 1'b1);
        check(columnDelayAndReferenceCal_q[13:0], 14'h1cf4);
        ctrl_i.mrs(3'h6, 14'h0415, 1'b1);
        waitPulse(4, 1'b0);
        settle();
        check(columnDelayAndReferenceCal_q[13:0], 14'h0495);
        check(parityErrorStatus, 1'b1);
        ctrl_i.mrs(3'h5, 14'h0201, 1'b0);
        waitPulse(4, 1'b0);
        settle();
        check({parityErrorStatus, parityPersistent}, 2'h1);
        repeat (2) begin
            ctrl_i.mrs(3'h6, 14'h0001, 1'b1);
            waitPulse(4, 1'b1);
            settle();
            check({parityErrorStatus, columnDelayAndReferenceCal_q[7:0]}, 9'h195);
        end
        ctrl_i.mrs(3'h5, 14'h0000, 1'b0);
        waitPulse(4, 1'b0);
        settle();
        check({parityErrorStatus, parityEnabled}, 2'h0);
    endtask : t_parity

    // one read and its accept or too-early outcome
    task automatic colChk(input logic [1:0] bg, input logic acc);
        ctrl_i.col(bg);
        @(negedge clock);
        check({columnCmdAccept, columnCmdTooEarly}, {acc, !acc});
    endtask : colChk

    // same group spacing at delay codes 2 and 0, giving 6 and 4 clocks
    task automatic t_column();
        ctrl_i.mrs(3'h6, 14'h0800, 1'b0);
        waitPulse(0, 1'b0);
        settle();
        colChk(2'h0, 1'b1);
        ctrl_i.idle(4);
        colChk(2'h0, 1'b0);
        colChk(2'h0, 1'b1);
        colChk(2'h1, 1'b1);
        ctrl_i.mrs(3'h6, 14'h0000, 1'b0);
        waitPulse(0, 1'b0);
        settle();
        colChk(2'h2, 1'b1);
        ctrl_i.idle(2);
        colChk(2'h2, 1'b0);
        colChk(2'h2, 1'b1);
    endtask : t_column

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        t_reset();
        t_mr6();
        t_crc();
        t_latency();
        t_parity();
        t_column();
        end_sim();
    end
endmodule : dram_mode_six_and_parity_status_tb_top
`default_nettype wire
